// ### gk_ring_pkg.sv
// constants for ground key detection and ringing control
package gk_ring_pkg;
   // register offsets
   localparam logic [5:0] OFS_LINE_STATE   = 6'h00;
   localparam logic [5:0] OFS_RING_CONTROL = 6'h04;
   localparam logic [5:0] OFS_RING_ACTIVE  = 6'h08;
   localparam logic [5:0] OFS_RING_INACT   = 6'h0c;
   localparam logic [5:0] OFS_RELAY_CTRL   = 6'h10;
   localparam logic [5:0] OFS_GK_DEBOUNCE  = 6'h14;
   localparam logic [5:0] OFS_GK_ASSERT    = 6'h18;
   localparam logic [5:0] OFS_GK_RELEASE   = 6'h1c;
   localparam logic [5:0] OFS_GK_COEFF     = 6'h20;
   localparam logic [5:0] OFS_LOOP_TRIP    = 6'h24;
   localparam logic [5:0] OFS_IRQ_VECTOR   = 6'h28;
   localparam logic [5:0] OFS_IRQ_ENABLE   = 6'h2c;
   localparam logic [5:0] OFS_GK_FILTERED  = 6'h30;
   // field positions
   localparam int RC_TRAP_BIT     = 0;
   localparam int RC_TA_EN_BIT    = 1;
   localparam int RC_TI_EN_BIT    = 2;
   localparam int RC_OSC_MON_BIT  = 3;
   localparam int LT_LOOP_BIT     = 0;
   localparam int LT_GK_BIT       = 1;
   localparam int IRQ_GK_BIT      = 0;
   localparam int IRQ_RING_TA_BIT = 1;
   localparam int IRQ_RING_TI_BIT = 2;
   localparam int IRQ_W           = 3;
   localparam int COEFF_LSB       = 3;
   localparam int COEFF_SHIFT     = 14;
   // reset values
   localparam logic [15:0] GK_COEFF_RST = 16'h0a10;
   localparam logic [15:0] ZERO16       = 16'h0000;
   // usable threshold limit, codes of 3.097 uA up to 16 mA
   localparam logic [15:0] GK_THR_LIMIT = 16'h142e;
   // line states
   typedef enum logic [2:0] {
      LS_OPEN       = 3'h0,
      LS_FWD_ACTIVE = 3'h1,
      LS_FWD_OHT    = 3'h2,
      LS_TIP_OPEN   = 3'h3,
      LS_RINGING    = 3'h4,
      LS_REV_ACTIVE = 3'h5,
      LS_REV_OHT    = 3'h6,
      LS_RING_OPEN  = 3'h7
   } line_state_e;
   // cadence phases, gray along idle, active, inactive
   typedef enum logic [1:0] {
      CAD_IDLE     = 2'b00,
      CAD_ACTIVE   = 2'b01,
      CAD_INACTIVE = 2'b11
   } cadence_e;
   // timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_PERIOD_NS  = 125000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RING_STEP_US    = 125;
   localparam int DEB_STEP_US     = 1250;
   localparam int TICKS_PER_DEB   = DEB_STEP_US / RING_STEP_US;
endpackage : gk_ring_pkg

// ### gk_ring_ctrl.sv
// ground key detection and ringing control with register port
//
// Operation
// - in tip open a rising loop closure moves the line to forward active by itself.
// - ground key detection is off while either threshold is above the 16 mA limit.
// - the debounce interval is a 16-bit count of 1.25 ms steps.
// - a ground key pending flag and its enable bit sit in the second irq vector and enable.
// - both thresholds are 16-bit codes compared with the filtered longitudinal current.
// - the filter coefficient is bits 15 to 3, zero blocks and 4000h passes straight.
// - a read-only ground key detect bit shows the debounced condition.
// - balanced ringing drives tip and ring in antiphase.
// - ringing starts and stops only where the wave crosses the on-hook voltage.
// - active and inactive cadence timers count 125 us steps, each with its own enable.
// - an enable bit gates the ringing relay driver output.
// - the debounced output changes only after the opposite input held the whole interval.
// - an assert threshold detects onset and a lower release threshold detects release.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module gk_ring_ctrl #(
   parameter int TICK_CYCLES = gk_ring_pkg::TICK_CYCLES_DEF,
   parameter int DW          = 16
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic [5:0]             addr_i,
   input  wire logic [DW-1:0]          wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [DW-1:0]          rdata_o,
   input  wire logic signed [DW-1:0]   longitudinal_current_sense_i,
   input  wire logic                   loop_closure_status_i,
   input  wire logic signed [DW-1:0]   onhook_line_voltage_i,
   input  wire logic signed [DW-1:0]   ring_wave_i,
   output logic signed [DW:0]          tip_wave_o,
   output logic signed [DW:0]          ring_wave_o,
   output logic                        ring_trapezoid_o,
   output logic                        relay_drive_o,
   output logic [2:0]                  line_state_shadow_o,
   output logic                        irq_o
);
   import gk_ring_pkg::*;

   function automatic logic [DW-1:0] abs_mag(input logic signed [DW-1:0] v);
      abs_mag = v[DW-1] ? DW'(-v) : v;
      if (v[DW-1] && abs_mag[DW-1])
         abs_mag = '1;
   endfunction : abs_mag

   line_state_e       line_state;
   cadence_e          cadence;
   logic [DW-1:0]     ring_active_time;
   logic [DW-1:0]     ring_inactive_time;
   logic [DW-1:0]     gnd_key_debounce_interval;
   logic [DW-1:0]     gnd_key_assert_threshold;
   logic [DW-1:0]     gnd_key_release_threshold;
   logic [DW-1:0]     gnd_key_filter_coeff;
   logic              ring_trap;
   logic              active_timer_enable;
   logic              inactive_timer_enable;
   logic              relay_driver_output_enable;
   logic              ring_oscillator_monitor;
   logic              gnd_key_detect_status;
   logic              gk_cmp;
   logic              loop_q;
   logic              cross_sign_q;
   logic [IRQ_W-1:0]  irq_vector_two;
   logic [IRQ_W-1:0]  irq_enable_two;
   logic [IRQ_W-1:0]  irq_events;
   logic [31:0]       tick_cnt;
   logic              tick;
   logic signed [DW-1:0] gk_filt;
   logic [DW-1:0]     gk_filt_abs;
   logic [DW-1:0]     coeff_eff;
   logic              thr_over;
   logic [19:0]       deb_cnt;
   logic [19:0]       deb_target;
   logic [DW-1:0]     cad_cnt;
   logic              ring_want;
   logic signed [DW:0] cross_diff;
   logic              crossing;
   logic signed [DW:0]        filt_diff;
   logic signed [DW+DW+1:0]   filt_prod;
   logic signed [DW:0]        filt_sum;

   wire wr_line = wr_i && (addr_i == OFS_LINE_STATE);

   // 125 us sample tick
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         tick_cnt <= '0;
      else if (tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end
   assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

   // register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ring_active_time           <= ZERO16;
         ring_inactive_time         <= ZERO16;
         gnd_key_debounce_interval  <= ZERO16;
         gnd_key_assert_threshold   <= ZERO16;
         gnd_key_release_threshold  <= ZERO16;
         gnd_key_filter_coeff       <= GK_COEFF_RST;
         ring_trap                  <= 1'b0;
         active_timer_enable        <= 1'b0;
         inactive_timer_enable      <= 1'b0;
         relay_driver_output_enable <= 1'b0;
         irq_enable_two             <= '0;
      end else if (wr_i) begin
         case (addr_i)
            OFS_RING_CONTROL: begin
               ring_trap             <= wdata_i[RC_TRAP_BIT];
               active_timer_enable   <= wdata_i[RC_TA_EN_BIT];
               inactive_timer_enable <= wdata_i[RC_TI_EN_BIT];
            end
            OFS_RING_ACTIVE:  ring_active_time           <= wdata_i;
            OFS_RING_INACT:   ring_inactive_time         <= wdata_i;
            OFS_RELAY_CTRL:   relay_driver_output_enable <= wdata_i[0];
            OFS_GK_DEBOUNCE:  gnd_key_debounce_interval  <= wdata_i;
            OFS_GK_ASSERT:    gnd_key_assert_threshold   <= wdata_i;
            OFS_GK_RELEASE:   gnd_key_release_threshold  <= wdata_i;
            OFS_GK_COEFF:     gnd_key_filter_coeff       <= wdata_i;
            OFS_IRQ_ENABLE:   irq_enable_two             <= wdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // line state with automatic forward or reverse active on loop closure
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_state <= LS_OPEN;
         loop_q     <= 1'b0;
      end else begin
         loop_q <= loop_closure_status_i;
         if (wr_line)
            line_state <= line_state_e'(wdata_i[2:0]);
         else if (loop_closure_status_i && !loop_q && line_state == LS_TIP_OPEN)
            line_state <= LS_FWD_ACTIVE;
         else if (loop_closure_status_i && !loop_q && line_state == LS_RING_OPEN)
            line_state <= LS_REV_ACTIVE;
      end
   end
   assign line_state_shadow_o = line_state;

   // ground key low-pass filter
   assign coeff_eff = {gnd_key_filter_coeff[DW-1:COEFF_LSB], 3'h0};
   always_comb begin
      filt_diff = {longitudinal_current_sense_i[DW-1], longitudinal_current_sense_i}
                  - {gk_filt[DW-1], gk_filt};
      filt_prod = filt_diff * $signed({1'b0, coeff_eff});
      filt_sum  = {gk_filt[DW-1], gk_filt} + (DW+1)'(filt_prod >>> COEFF_SHIFT);
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         gk_filt <= '0;
      else if (tick)
         gk_filt <= filt_sum[DW-1:0];
   end
   assign gk_filt_abs = abs_mag(gk_filt);

   // threshold comparator with hysteresis
   assign thr_over = (gnd_key_assert_threshold > GK_THR_LIMIT)
                     || (gnd_key_release_threshold > GK_THR_LIMIT);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         gk_cmp <= 1'b0;
      else if (thr_over)
         gk_cmp <= 1'b0;
      else if (!gk_cmp && gk_filt_abs > gnd_key_assert_threshold)
         gk_cmp <= 1'b1;
      else if (gk_cmp && gk_filt_abs < gnd_key_release_threshold)
         gk_cmp <= 1'b0;
   end

   // debounce in 1.25 ms steps of ten sample ticks
   assign deb_target = 20'(gnd_key_debounce_interval * TICKS_PER_DEB);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         deb_cnt               <= '0;
         gnd_key_detect_status <= 1'b0;
      end else if (gk_cmp == gnd_key_detect_status) begin
         deb_cnt <= '0;
      end else if (deb_cnt >= deb_target) begin
         gnd_key_detect_status <= gk_cmp;
         deb_cnt               <= '0;
      end else if (tick) begin
         deb_cnt <= deb_cnt + 20'h1;
      end
   end

   // ringing cadence
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cadence <= CAD_IDLE;
         cad_cnt <= '0;
      end else if (line_state != LS_RINGING) begin
         cadence <= CAD_IDLE;
         cad_cnt <= '0;
      end else begin
         case (cadence)
            CAD_IDLE: begin
               cadence <= CAD_ACTIVE;
               cad_cnt <= '0;
            end
            CAD_ACTIVE:
               if (tick && active_timer_enable) begin
                  if (cad_cnt >= ring_active_time) begin
                     cadence <= CAD_INACTIVE;
                     cad_cnt <= '0;
                  end else
                     cad_cnt <= cad_cnt + 16'h1;
               end
            CAD_INACTIVE:
               if (tick && inactive_timer_enable) begin
                  if (cad_cnt >= ring_inactive_time) begin
                     cadence <= CAD_ACTIVE;
                     cad_cnt <= '0;
                  end else
                     cad_cnt <= cad_cnt + 16'h1;
               end
            default: cadence <= CAD_IDLE;
         endcase
      end
   end
   assign ring_want = (cadence == CAD_ACTIVE);

   // apply and remove ringing at on-hook voltage crossings
   assign cross_diff = {ring_wave_i[DW-1], ring_wave_i}
                       - {onhook_line_voltage_i[DW-1], onhook_line_voltage_i};
   assign crossing = (cross_diff[DW] != cross_sign_q) || (cross_diff == '0);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cross_sign_q            <= 1'b0;
         ring_oscillator_monitor <= 1'b0;
      end else begin
         cross_sign_q <= cross_diff[DW];
         if (crossing)
            ring_oscillator_monitor <= ring_want;
      end
   end

   // balanced drive and relay output
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tip_wave_o    <= '0;
         ring_wave_o   <= '0;
         relay_drive_o <= 1'b0;
      end else begin
         tip_wave_o    <= ring_oscillator_monitor ? {ring_wave_i[DW-1], ring_wave_i} : '0;
         ring_wave_o   <= ring_oscillator_monitor ? -{ring_wave_i[DW-1], ring_wave_i} : '0;
         relay_drive_o <= relay_driver_output_enable && ring_oscillator_monitor;
      end
   end
   assign ring_trapezoid_o = ring_trap;

   // interrupt vector, set wins over write-one-to-clear
   assign irq_events[IRQ_GK_BIT] = gk_cmp && !gnd_key_detect_status
                                   && deb_cnt >= deb_target;
   assign irq_events[IRQ_RING_TA_BIT] = (cadence == CAD_ACTIVE) && tick && active_timer_enable
                                        && cad_cnt >= ring_active_time;
   assign irq_events[IRQ_RING_TI_BIT] = (cadence == CAD_INACTIVE) && tick
                                        && inactive_timer_enable
                                        && cad_cnt >= ring_inactive_time;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         irq_vector_two <= '0;
      else if (wr_i && addr_i == OFS_IRQ_VECTOR)
         irq_vector_two <= (irq_vector_two & ~wdata_i[IRQ_W-1:0]) | irq_events;
      else
         irq_vector_two <= irq_vector_two | irq_events;
   end
   assign irq_o = |(irq_vector_two & irq_enable_two);

   // read data one cycle after the strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         rdata_o <= '0;
      else if (rd_i) begin
         case (addr_i)
            OFS_LINE_STATE:   rdata_o <= DW'(line_state);
            OFS_RING_CONTROL: rdata_o <= DW'({ring_oscillator_monitor, inactive_timer_enable,
                                              active_timer_enable, ring_trap});
            OFS_RING_ACTIVE:  rdata_o <= ring_active_time;
            OFS_RING_INACT:   rdata_o <= ring_inactive_time;
            OFS_RELAY_CTRL:   rdata_o <= DW'(relay_driver_output_enable);
            OFS_GK_DEBOUNCE:  rdata_o <= gnd_key_debounce_interval;
            OFS_GK_ASSERT:    rdata_o <= gnd_key_assert_threshold;
            OFS_GK_RELEASE:   rdata_o <= gnd_key_release_threshold;
            OFS_GK_COEFF:     rdata_o <= coeff_eff;
            OFS_LOOP_TRIP:    rdata_o <= DW'({gnd_key_detect_status, loop_closure_status_i});
            OFS_IRQ_VECTOR:   rdata_o <= DW'(irq_vector_two);
            OFS_IRQ_ENABLE:   rdata_o <= DW'(irq_enable_two);
            OFS_GK_FILTERED:  rdata_o <= gk_filt;
            default:          rdata_o <= '0;
         endcase
      end else
         rdata_o <= '0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   auto_fwd_a: assert property (line_state == LS_TIP_OPEN && loop_closure_status_i && !loop_q
      && !wr_line |=> line_state == LS_FWD_ACTIVE) else $error("no automatic forward active");
   thr_limit_a: assert property (thr_over |=> !gk_cmp)
      else $error("comparator active above threshold limit");
   deb_count_a: assert property ($changed(gnd_key_detect_status) |->
      $past(deb_cnt) >= $past(deb_target)) else $error("debounce ended early");
   pend_set_a: assert property ($rose(gnd_key_detect_status) |-> irq_vector_two[IRQ_GK_BIT])
      else $error("pending flag not set on detect");
   onset_cmp_a: assert property ($rose(gk_cmp) |-> $past(gk_filt_abs) >
      $past(gnd_key_assert_threshold)) else $error("onset below threshold");
   filt_block_a: assert property (tick && coeff_eff == '0 |=> $stable(gk_filt))
      else $error("zero coefficient let signal through");
   deb_follow_a: assert property ($changed(gnd_key_detect_status) |->
      gnd_key_detect_status == $past(gk_cmp)) else $error("debounce took wrong level");
   antiphase_a: assert property (ring_wave_o == -tip_wave_o)
      else $error("tip and ring not in antiphase");
   ring_cross_a: assert property ($changed(ring_oscillator_monitor) |-> $past(crossing))
      else $error("ringing changed off a crossing");
   cad_end_a: assert property (cadence == CAD_ACTIVE && line_state == LS_RINGING && tick
      && active_timer_enable && cad_cnt >= ring_active_time |=> cadence == CAD_INACTIVE)
      else $error("active timer expiry missed");
   relay_gate_a: assert property (relay_drive_o |-> $past(relay_driver_output_enable))
      else $error("relay driven while disabled");
   release_a: assert property ($fell(gk_cmp) |-> $past(thr_over) ||
      $past(gk_filt_abs) < $past(gnd_key_release_threshold)) else $error("bad release");
   irq_mask_a: assert property ($rose(gnd_key_detect_status) && irq_enable_two[IRQ_GK_BIT] |-> irq_o)
      else $error("enabled ground key detect gave no interrupt");

   gk_detect_c: cover property ($rose(gnd_key_detect_status));
   ring_cycle_c: cover property (cadence == CAD_ACTIVE ##1 cadence == CAD_INACTIVE);
   auto_fwd_c: cover property (line_state == LS_TIP_OPEN ##1 line_state == LS_FWD_ACTIVE);
endmodule : gk_ring_ctrl
`default_nettype wire

// ### test_ground_key_and_ringing_control.sv
// self-checking bench for ground key detection and ringing control
`timescale 1ns/1ps
`default_nettype none
module test_ground_key_and_ringing_control;
   import gk_ring_pkg::*;
   localparam int TC = 4;
   logic                clk_i;
   logic                rst_i;
   logic [5:0]          addr_i;
   logic [15:0]         wdata_i;
   logic                wr_i;
   logic                rd_i;
   logic [15:0]         rdata_o;
   logic signed [15:0]  cur;
   logic                loop_cl;
   logic signed [15:0]  onhook;
   logic signed [15:0]  wave;
   logic signed [16:0]  tip_o;
   logic signed [16:0]  ring_o;
   logic                trap_o;
   logic                relay_o;
   logic [2:0]          shadow_o;
   logic                irq_o;
   int                  miscompares;
   int                  checks_done;
   logic [15:0]         exp_q[$];
   logic [15:0]         msk_q[$];
   logic                rd_seen;
   logic [15:0]         em;
   logic [15:0]         mm;
   logic [15:0]         x;
   logic [15:0]         v;
   logic signed [16:0]  e;

   gk_ring_ctrl #(.TICK_CYCLES(TC), .DW(16)) gk_ring_ctrl_inst (
      .clk_i                        (clk_i),
      .rst_i                        (rst_i),
      .addr_i                       (addr_i),
      .wdata_i                      (wdata_i),
      .wr_i                         (wr_i),
      .rd_i                         (rd_i),
      .rdata_o                      (rdata_o),
      .longitudinal_current_sense_i (cur),
      .loop_closure_status_i        (loop_cl),
      .onhook_line_voltage_i        (onhook),
      .ring_wave_i                  (wave),
      .tip_wave_o                   (tip_o),
      .ring_wave_o                  (ring_o),
      .ring_trapezoid_o             (trap_o),
      .relay_drive_o                (relay_o),
      .line_state_shadow_o          (shadow_o),
      .irq_o                        (irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic cmp(input string n, input logic [16:0] ex, input logic [16:0] got);
      checks_done++;
      if (got !== ex) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, ex, got);
      end
   endtask : cmp

   task automatic wrap_up;
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [15:0] ex, input logic [15:0] m);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      exp_q.push_back(ex & m);
      msk_q.push_back(m);
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask : rd

   // read data watcher, one cycle after each read strobe
   always @(posedge clk_i) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("MISMATCH rdata expected none seen %h", rdata_o);
         end else begin
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            cmp("rdata", {1'b0, em}, {1'b0, rdata_o & mm});
         end
      end
      rd_seen <= rd_i;
   end

   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end

   initial begin
      rst_i       = 1'b1;
      wr_i        = 1'b0;
      rd_i        = 1'b0;
      addr_i      = 6'h00;
      wdata_i     = 16'h0000;
      cur         = 16'sh0000;
      loop_cl     = 1'b0;
      onhook      = 16'sh0000;
      wave        = 16'sh0064;
      miscompares = 0;
      checks_done = 0;
      void'($urandom(32'hf0fd149a));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values and unmapped place
      cmp("irq", 17'h00000, {16'h0000, irq_o});
      rd(OFS_GK_COEFF, GK_COEFF_RST, 16'hffff);
      rd(OFS_LINE_STATE, 16'h0000, 16'hffff);
      rd(OFS_IRQ_VECTOR, 16'h0000, 16'hffff);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'hffff);
      rd(6'h3c, 16'h0000, 16'hffff);
      // zero coefficient blocks the current
      x = 16'd200 + 16'($urandom % 3800);
      wr(OFS_GK_COEFF, 16'h0000);
      wr(OFS_GK_ASSERT, 16'd100);
      wr(OFS_GK_RELEASE, 16'd50);
      wr(OFS_GK_DEBOUNCE, 16'h0000);
      cur <= x;
      cyc(20);
      rd(OFS_GK_FILTERED, 16'h0000, 16'hffff);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'h0002);
      // full coefficient passes straight, detect and pending
      wr(OFS_GK_COEFF, 16'h4007);
      rd(OFS_GK_COEFF, 16'h4000, 16'hffff);
      cyc(20);
      rd(OFS_GK_FILTERED, x, 16'hffff);
      rd(OFS_LOOP_TRIP, 16'h0002, 16'h0002);
      rd(OFS_IRQ_VECTOR, 16'h0001, 16'h0001);
      cmp("irq", 17'h00000, {16'h0000, irq_o});
      wr(OFS_IRQ_ENABLE, 16'h0001);
      cyc(2);
      cmp("irq", 17'h00001, {16'h0000, irq_o});
      wr(OFS_IRQ_ENABLE, 16'h0000);
      cyc(2);
      cmp("irq", 17'h00000, {16'h0000, irq_o});
      wr(OFS_IRQ_ENABLE, 16'h0001);
      wr(OFS_IRQ_VECTOR, 16'h0001);
      cyc(2);
      cmp("irq", 17'h00000, {16'h0000, irq_o});
      // hysteresis between the two thresholds
      cur <= 16'sd75;
      cyc(20);
      rd(OFS_LOOP_TRIP, 16'h0002, 16'h0002);
      cur <= 16'sd20;
      cyc(20);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'h0002);
      // threshold limit boundary
      wr(OFS_GK_ASSERT, 16'h142f);
      cur <= 16'sd5200;
      cyc(20);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'h0002);
      wr(OFS_GK_ASSERT, 16'h142e);
      cyc(20);
      rd(OFS_LOOP_TRIP, 16'h0002, 16'h0002);
      wr(OFS_GK_RELEASE, 16'h142f);
      cyc(20);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'h0002);
      cur <= 16'sh0000;
      wr(OFS_GK_DEBOUNCE, 16'h0001);
      wr(OFS_GK_RELEASE, 16'd50);
      wr(OFS_GK_ASSERT, 16'd100);
      // debounce of ten ticks, negative current by magnitude
      cur <= -$signed(16'd200 + 16'($urandom % 3800));
      cyc(12);
      rd(OFS_LOOP_TRIP, 16'h0000, 16'h0002);
      cyc(60);
      rd(OFS_LOOP_TRIP, 16'h0002, 16'h0002);
      // tip open moves to forward active on loop closure
      wr(OFS_LINE_STATE, 16'h0003);
      rd(OFS_LINE_STATE, 16'h0003, 16'h0007);
      loop_cl <= 1'b1;
      cyc(4);
      rd(OFS_LINE_STATE, 16'h0001, 16'h0007);
      rd(OFS_LOOP_TRIP, 16'h0001, 16'h0001);
      loop_cl <= 1'b0;
      wr(OFS_LINE_STATE, 16'h0007);
      loop_cl <= 1'b1;
      cyc(4);
      rd(OFS_LINE_STATE, 16'h0005, 16'h0007);
      loop_cl <= 1'b0;
      // ringing cadence, crossings and relay
      v = 16'd100 + 16'($urandom % 5000);
      e = -$signed({1'b0, v});
      wave <= v;
      wr(OFS_RING_CONTROL, 16'h0007);
      wr(OFS_RING_ACTIVE, 16'd20);
      wr(OFS_RING_INACT, 16'd20);
      wr(OFS_RELAY_CTRL, 16'h0001);
      cmp("trap", 17'h00001, {16'h0000, trap_o});
      wr(OFS_LINE_STATE, 16'h0004);
      cyc(8);
      cmp("tip", 17'h00000, tip_o);
      cmp("relay", 17'h00000, {16'h0000, relay_o});
      wave <= e[15:0];
      cyc(4);
      cmp("tip", e, tip_o);
      cmp("ring", {1'b0, v}, ring_o);
      cmp("relay", 17'h00001, {16'h0000, relay_o});
      rd(OFS_RING_CONTROL, 16'h0008, 16'h0008);
      cyc(100);
      wave <= v;
      cyc(4);
      cmp("tip", 17'h00000, tip_o);
      rd(OFS_IRQ_VECTOR, 16'h0002, 16'h0002);
      cyc(70);
      wave <= e[15:0];
      cyc(4);
      cmp("tip", e, tip_o);
      rd(OFS_IRQ_VECTOR, 16'h0004, 16'h0004);
      wr(OFS_RELAY_CTRL, 16'h0000);
      cyc(2);
      cmp("relay", 17'h00000, {16'h0000, relay_o});
      wr(OFS_LINE_STATE, 16'h0000);
      cyc(2);
      wave <= v;
      cyc(4);
      cmp("tip", 17'h00000, tip_o);
      cmp("shadow", 17'h00000, {14'h0000, shadow_o});
      cyc(4);
      if (exp_q.size() != 0) begin
         miscompares++;
      end
      wrap_up();
   end
endmodule : test_ground_key_and_ringing_control
`default_nettype wire
